// ---- src/serdes_quad_regs_pkg.sv ----
// Constants for the SERDES quad control and status register bank
package serdes_quad_regs_pkg;

   // ==========================================================
   // Bus geometry
   localparam int unsigned ADDR_W = 20;
   localparam int unsigned DATA_W = 32;

   // ==========================================================
   // Register indices and byte addresses (byte address = 4 * index)
   localparam logic [ADDR_W-1:0] XAUI_STAT_IDX  = 20'h30804;
   localparam logic [ADDR_W-1:0] CLK_CTRL_IDX   = 20'h30821;
   localparam logic [ADDR_W-1:0] CHAR_CTRL_IDX  = 20'h30830;
   localparam logic [ADDR_W-1:0] XAUI_STAT_ADDR = XAUI_STAT_IDX << 2;
   localparam logic [ADDR_W-1:0] CLK_CTRL_ADDR  = CLK_CTRL_IDX << 2;
   localparam logic [ADDR_W-1:0] CHAR_CTRL_ADDR = CHAR_CTRL_IDX << 2;

   // ==========================================================
   // Field positions
   localparam int unsigned BYPASS_BIT   = 0;
   localparam int unsigned RX_SEL_LSB   = 4;
   localparam int unsigned TX_SEL_LSB   = 6;
   localparam int unsigned CHAR_EN_BIT  = 4;
   localparam int unsigned CHAR_TX_BIT  = 5;
   localparam int unsigned CHAR_CH_LSB  = 6;

   // ==========================================================
   // Reset values and register masks
   localparam logic [7:0] CLK_CTRL_RST  = 8'h00;
   localparam logic [7:0] CHAR_CTRL_RST = 8'h00;
   localparam logic [7:0] XAUI_STAT_RST = 8'h00;
   localparam logic [7:0] CLK_CTRL_MASK  = 8'hf1;
   localparam logic [7:0] CHAR_CTRL_MASK = 8'hf0;

   // ==========================================================
   // Encodings
   localparam logic [1:0] REFCLK_A = 2'h0;
   localparam logic [1:0] REFCLK_B = 2'h2;
   localparam logic [1:0] REFCLK_C = 2'h1;
   localparam logic [1:0] REFCLK_D = 2'h3;

   typedef enum logic [1:0] {
      LINK_NO_SYNC  = 2'b00,
      LINK_NO_COMMA = 2'b01,
      LINK_SYNCED   = 2'b10,
      LINK_UNUSED   = 2'b11
   } link_state_t;

   // ==========================================================
   // Pin synchroniser
   localparam int unsigned PIN_W     = 14;
   localparam logic [PIN_W-1:0] PIN_RST = 14'h0000;
   localparam int unsigned LS_W      = 10;
   localparam int unsigned OBS_W     = 16;

endpackage

// ---- src/serdes_quad_ctrl_status_regs.sv ----
// APB register bank and characterization routing for a SERDES quad
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module serdes_quad_ctrl_status_regs (
   input  wire logic        core_clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [19:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Quad controls
   output logic             alignmentFifoBypass,
   input  wire logic        xauiStateMachineSelect,
   input  wire logic [7:0]  xauiLinkStateIn,
   input  wire logic [3:0]  rxByteClockZero,
   input  wire logic [3:0]  txRefClockIn,
   output logic             sharedRxRefClockOut,
   output logic             sharedTxRefClockOut,
   // Characterization qualifiers (pins)
   input  wire logic [1:0]  testModeInputs,
   input  wire logic        fabricSpi4EnableInput,
   // Per-channel observation sources
   input  wire logic [3:0]  txByteClock,
   input  wire logic [3:0]  codeViolationFlag,
   input  wire logic [3:0]  byteSyncFlag,
   input  wire logic [3:0]  wordSyncFlag,
   input  wire logic [3:0]  rxByteClockOne,
   input  wire logic [39:0] lowSpeedRxData,
   // Data pins 20..35, index 0 is pin 20
   output logic [15:0]      hostIfDataPinsOut,
   output logic             hostIfDataPinsOeN,
   // Address pins 5..15
   input  wire logic [15:5] hostIfAddressPins,
   // Transmit low-speed path
   input  wire logic [3:0]  normTxByteClock,
   input  wire logic [39:0] normLowSpeedTxData,
   output logic [3:0]       txByteClockOut,
   output logic [39:0]      lowSpeedTxData
);

   // ==========================================================
   // Declarations
   logic [7:0]  clkCtrl_reg;
   logic [7:0]  charCtrl_reg;
   logic [7:0]  xaui_link_state_field_reg;
   logic [7:0]  xaui_link_state_field_next;
   logic [31:0] prdata_reg;
   logic        pslverr_reg;
   logic [31:0] rdata_next;
   logic        hit_next;
   logic        setupPhase;
   logic        wrAccess;
   logic [serdes_quad_regs_pkg::PIN_W-1:0] pinRaw;
   logic [serdes_quad_regs_pkg::PIN_W-1:0] syncS1_reg;
   logic [serdes_quad_regs_pkg::PIN_W-1:0] syncS2_reg;
   logic [serdes_quad_regs_pkg::PIN_W-1:0] syncS3_reg;
   logic [serdes_quad_regs_pkg::PIN_W-1:0] pinFilt_reg;
   logic [1:0]  testModeSync;
   logic        spi4EnSync;
   logic [10:0] addrPinSync;
   logic [1:0]  rxSel;
   logic [1:0]  txSel;
   logic [1:0]  charChan;
   logic        charEnable;
   logic        charTxDrive;
   logic        charActive;
   logic [9:0]  selRxData;
   logic [15:0] obsWord;
   logic [15:0] obsData_reg;
   logic        obsOeN_reg;
   logic [3:0]  txClk_reg;
   logic [39:0] txData_reg;

   assign rxSel       = clkCtrl_reg[serdes_quad_regs_pkg::RX_SEL_LSB +: 2];
   assign txSel       = clkCtrl_reg[serdes_quad_regs_pkg::TX_SEL_LSB +: 2];
   assign charEnable  = charCtrl_reg[serdes_quad_regs_pkg::CHAR_EN_BIT];
   assign charTxDrive = charCtrl_reg[serdes_quad_regs_pkg::CHAR_TX_BIT];
   assign charChan    = charCtrl_reg[serdes_quad_regs_pkg::CHAR_CH_LSB +: 2];

   // ==========================================================
   // APB slave
   assign setupPhase = psel && !penable;
   assign wrAccess   = psel && penable && pwrite && pstrb[0];
   assign pready     = 1'b1;
   assign prdata     = prdata_reg;
   assign pslverr    = pslverr_reg;

   always_comb begin
      rdata_next = 32'h0000_0000;
      hit_next   = 1'b1;
      case (paddr)
         serdes_quad_regs_pkg::XAUI_STAT_ADDR: begin
            rdata_next[7:0] = xaui_link_state_field_reg;
         end
         serdes_quad_regs_pkg::CLK_CTRL_ADDR: begin
            rdata_next[7:0] = clkCtrl_reg &
                              serdes_quad_regs_pkg::CLK_CTRL_MASK;
         end
         serdes_quad_regs_pkg::CHAR_CTRL_ADDR: begin
            rdata_next[7:0] = charCtrl_reg &
                              serdes_quad_regs_pkg::CHAR_CTRL_MASK;
         end
         default: begin
            hit_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (setupPhase) begin
         prdata_reg  <= pwrite ? 32'h0000_0000 : rdata_next;
         pslverr_reg <= !hit_next;
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         clkCtrl_reg <= serdes_quad_regs_pkg::CLK_CTRL_RST;
      end else if (wrAccess &&
                   paddr == serdes_quad_regs_pkg::CLK_CTRL_ADDR) begin
         clkCtrl_reg <= pwdata[7:0] & serdes_quad_regs_pkg::CLK_CTRL_MASK;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         charCtrl_reg <= serdes_quad_regs_pkg::CHAR_CTRL_RST;
      end else if (wrAccess &&
                   paddr == serdes_quad_regs_pkg::CHAR_CTRL_ADDR) begin
         charCtrl_reg <= pwdata[7:0] &
                         serdes_quad_regs_pkg::CHAR_CTRL_MASK;
      end
   end

   assign alignmentFifoBypass =
      clkCtrl_reg[serdes_quad_regs_pkg::BYPASS_BIT];

   // ==========================================================
   // Shared reference clock selection
   always_comb begin
      case (rxSel)
         serdes_quad_regs_pkg::REFCLK_A:
            sharedRxRefClockOut = rxByteClockZero[0];
         serdes_quad_regs_pkg::REFCLK_B:
            sharedRxRefClockOut = rxByteClockZero[1];
         serdes_quad_regs_pkg::REFCLK_C:
            sharedRxRefClockOut = rxByteClockZero[2];
         serdes_quad_regs_pkg::REFCLK_D:
            sharedRxRefClockOut = rxByteClockZero[3];
         default: sharedRxRefClockOut = rxByteClockZero[0];
      endcase
   end

   always_comb begin
      case (txSel)
         serdes_quad_regs_pkg::REFCLK_A: sharedTxRefClockOut = txRefClockIn[0];
         serdes_quad_regs_pkg::REFCLK_B: sharedTxRefClockOut = txRefClockIn[1];
         serdes_quad_regs_pkg::REFCLK_C: sharedTxRefClockOut = txRefClockIn[2];
         serdes_quad_regs_pkg::REFCLK_D: sharedTxRefClockOut = txRefClockIn[3];
         default: sharedTxRefClockOut = txRefClockIn[0];
      endcase
   end

   // ==========================================================
   // Link status register
   always_comb begin
      xaui_link_state_field_next = serdes_quad_regs_pkg::XAUI_STAT_RST;
      for (int c = 0; c < 4; c++) begin
         if (xauiStateMachineSelect &&
             xauiLinkStateIn[2*c +: 2] !=
             serdes_quad_regs_pkg::LINK_UNUSED) begin
            xaui_link_state_field_next[2*c +: 2] = xauiLinkStateIn[2*c +: 2];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         xaui_link_state_field_reg <= serdes_quad_regs_pkg::XAUI_STAT_RST;
      end else begin
         xaui_link_state_field_reg <= xaui_link_state_field_next;
      end
   end

   // ==========================================================
   // Pin synchroniser, change taken when stages two and three agree
   assign pinRaw = {fabricSpi4EnableInput, testModeInputs, hostIfAddressPins};

   always_ff @(posedge core_clk) begin
      if (rst) begin
         syncS1_reg  <= serdes_quad_regs_pkg::PIN_RST;
         syncS2_reg  <= serdes_quad_regs_pkg::PIN_RST;
         syncS3_reg  <= serdes_quad_regs_pkg::PIN_RST;
         pinFilt_reg <= serdes_quad_regs_pkg::PIN_RST;
      end else begin
         syncS1_reg <= pinRaw;
         syncS2_reg <= syncS1_reg;
         syncS3_reg <= syncS2_reg;
         for (int b = 0; b < serdes_quad_regs_pkg::PIN_W; b++) begin
            if (syncS2_reg[b] == syncS3_reg[b]) begin
               pinFilt_reg[b] <= syncS3_reg[b];
            end
         end
      end
   end

   assign addrPinSync  = pinFilt_reg[10:0];
   assign testModeSync = pinFilt_reg[12:11];
   assign spi4EnSync   = pinFilt_reg[13];

   // ==========================================================
   // Characterization mode
   assign charActive = charEnable && testModeSync == 2'b00 &&
                       !spi4EnSync;

   assign selRxData = lowSpeedRxData[charChan*10 +: 10];

   always_comb begin
      obsWord[0] = txByteClock[charChan];
      obsWord[1] = codeViolationFlag[charChan];
      obsWord[2] = byteSyncFlag[charChan];
      obsWord[3] = wordSyncFlag[charChan];
      obsWord[4] = rxByteClockZero[charChan];
      obsWord[5] = rxByteClockOne[charChan];
      for (int i = 0; i < serdes_quad_regs_pkg::LS_W; i++) begin
         obsWord[6+i] = selRxData[9-i];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         obsData_reg <= 16'h0000;
         obsOeN_reg  <= 1'b1;
      end else begin
         obsData_reg <= charActive ? obsWord : 16'h0000;
         obsOeN_reg  <= !charActive;
      end
   end

   assign hostIfDataPinsOut = obsData_reg;
   assign hostIfDataPinsOeN = obsOeN_reg;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         txClk_reg  <= 4'h0;
         txData_reg <= 40'h00_0000_0000;
      end else begin
         txClk_reg  <= normTxByteClock;
         txData_reg <= normLowSpeedTxData;
         if (charActive && charTxDrive) begin
            txClk_reg[charChan]           <= addrPinSync[10];
            txData_reg[charChan*10 +: 10] <= addrPinSync[9:0];
         end
      end
   end

   assign txByteClockOut = txClk_reg;
   assign lowSpeedTxData = txData_reg;

   // ==========================================================
   // Assertions
   a_bypass_write: assert property (@(posedge core_clk)
      disable iff (rst)
      wrAccess && paddr == serdes_quad_regs_pkg::CLK_CTRL_ADDR
      |=> alignmentFifoBypass == $past(pwdata[0]))
      else $error("bypass bit did not follow write");

   a_rx_clock_pick: assert property (@(posedge core_clk)
      disable iff (rst)
      rxSel == 2'b10 |-> sharedRxRefClockOut == rxByteClockZero[1])
      else $error("rx clock select 10 did not pick channel B");

   a_tx_clock_pick: assert property (@(posedge core_clk)
      disable iff (rst)
      txSel == 2'b01 |-> sharedTxRefClockOut == txRefClockIn[2])
      else $error("tx clock select 01 did not pick channel C");

   a_char_gate: assert property (@(posedge core_clk) disable iff (rst)
      (testModeSync != 2'b00 || spi4EnSync) |=> hostIfDataPinsOeN)
      else $error("data pins driven while mode qualifiers fail");

   a_obs_bus: assert property (@(posedge core_clk) disable iff (rst)
      charActive && charChan == 2'b10
      |=> !hostIfDataPinsOeN
          && hostIfDataPinsOut[15] == $past(lowSpeedRxData[20])
          && hostIfDataPinsOut[1] == $past(codeViolationFlag[2]))
      else $error("observed channel C not on data pins");

   a_tx_override: assert property (@(posedge core_clk) disable iff (rst)
      charActive && charTxDrive && charChan == 2'b10
      |=> lowSpeedTxData[29:20] == $past(addrPinSync[9:0])
          && txByteClockOut[2] == $past(addrPinSync[10]))
      else $error("tx override from address pins missing");

   a_tx_normal: assert property (@(posedge core_clk) disable iff (rst)
      !charActive |=> lowSpeedTxData == $past(normLowSpeedTxData))
      else $error("tx data not from normal source");

   a_no_unused: assert property (@(posedge core_clk) disable iff (rst)
      xaui_link_state_field_reg[1:0] != 2'b11 && xaui_link_state_field_reg[3:2] != 2'b11 &&
      xaui_link_state_field_reg[5:4] != 2'b11 && xaui_link_state_field_reg[7:6] != 2'b11)
      else $error("unused link code reported");

   a_status_follow: assert property (@(posedge core_clk)
      disable iff (rst)
      xauiStateMachineSelect && xauiLinkStateIn[3:2] != 2'b11
      |=> xaui_link_state_field_reg[3:2] == $past(xauiLinkStateIn[3:2]))
      else $error("link status of channel B not reported");

   a_status_reset: assert property (@(posedge core_clk)
      $past(rst) |-> xaui_link_state_field_reg == 8'h00)
      else $error("link status not zero after reset");

   a_xaui_gate: assert property (@(posedge core_clk) disable iff (rst)
      !xauiStateMachineSelect |=> xaui_link_state_field_reg == 8'h00)
      else $error("link status reported outside Xaui_state_machine_select");

   a_reserved_zero: assert property (@(posedge core_clk)
      disable iff (rst)
      setupPhase && !pwrite && paddr == serdes_quad_regs_pkg::CLK_CTRL_ADDR
      |=> prdata[3:1] == 3'b000 && prdata[31:8] == 24'h000000)
      else $error("reserved control bits read nonzero");

endmodule

`default_nettype wire

// ---- dv/serdes_quad_ctrl_status_regs_tb_top.sv ----
// Self-checking testbench for the SERDES quad register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
   failures++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
   end end

module serdes_quad_ctrl_status_regs_tb_top;
   // ==========================================
   // Signals
   logic        core_clk = 1'b0;
   logic        rst, psel, penable, pwrite, pready, pslverr;
   logic [19:0] paddr;
   logic [31:0] pwdata, prdata, rdData;
   logic [3:0]  pstrb, rxByteClockZero, txRefClockIn, txByteClock;
   logic [3:0]  codeViolationFlag, byteSyncFlag, wordSyncFlag;
   logic [3:0]  rxByteClockOne, normTxByteClock, txByteClockOut;
   logic        alignmentFifoBypass, xauiStateMachineSelect, rdErr;
   logic        sharedRxRefClockOut, sharedTxRefClockOut;
   logic        fabricSpi4EnableInput, hostIfDataPinsOeN;
   logic [7:0]  xauiLinkStateIn;
   logic [1:0]  testModeInputs;
   logic [39:0] lowSpeedRxData, normLowSpeedTxData, lowSpeedTxData;
   logic [15:0] hostIfDataPinsOut;
   logic [15:5] hostIfAddressPins;
   int          failures = 0;
   int          compares = 0;
   int          cycles = 0;
   int          chOf [4] = '{0, 2, 1, 3};
   localparam logic [19:0] CLK = serdes_quad_regs_pkg::CLK_CTRL_ADDR;
   localparam logic [19:0] CHR = serdes_quad_regs_pkg::CHAR_CTRL_ADDR;
   localparam logic [19:0] STA = serdes_quad_regs_pkg::XAUI_STAT_ADDR;

   serdes_quad_ctrl_status_regs u_serdes_quad_ctrl_status_regs (
      .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .alignmentFifoBypass(alignmentFifoBypass),
      .xauiStateMachineSelect(xauiStateMachineSelect),
      .xauiLinkStateIn(xauiLinkStateIn), .rxByteClockZero(rxByteClockZero),
      .txRefClockIn(txRefClockIn), .sharedRxRefClockOut(sharedRxRefClockOut),
      .sharedTxRefClockOut(sharedTxRefClockOut),
      .testModeInputs(testModeInputs),
      .fabricSpi4EnableInput(fabricSpi4EnableInput),
      .txByteClock(txByteClock), .codeViolationFlag(codeViolationFlag),
      .byteSyncFlag(byteSyncFlag), .wordSyncFlag(wordSyncFlag),
      .rxByteClockOne(rxByteClockOne), .lowSpeedRxData(lowSpeedRxData),
      .hostIfDataPinsOut(hostIfDataPinsOut),
      .hostIfDataPinsOeN(hostIfDataPinsOeN),
      .hostIfAddressPins(hostIfAddressPins),
      .normTxByteClock(normTxByteClock),
      .normLowSpeedTxData(normLowSpeedTxData),
      .txByteClockOut(txByteClockOut), .lowSpeedTxData(lowSpeedTxData)
   );

   always #2.5 core_clk = ~core_clk;

   // ==========================================
   // Verdict and timeout
   task automatic give_verdict();
      if (failures == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         give_verdict();
      end
   end

   // ==========================================
   // APB access
   task automatic apb(input logic wr, input logic [19:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rdData = prdata;
      rdErr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
      `CHK(rdErr, 1'b0)
   endtask

   task automatic rdChk(input logic [19:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'hf);
      `CHK(rdData, e)
      `CHK(rdErr, 1'b0)
   endtask

   // ==========================================
   // Expected characterization values
   function automatic logic [15:0] expPins(int c);
      logic [15:0] p;
      p[0] = txByteClock[c];
      p[1] = codeViolationFlag[c];
      p[2] = byteSyncFlag[c];
      p[3] = wordSyncFlag[c];
      p[4] = rxByteClockZero[c];
      p[5] = rxByteClockOne[c];
      for (int i = 0; i < 10; i++) p[6+i] = lowSpeedRxData[10*c+9-i];
      return p;
   endfunction

   function automatic logic [39:0] expLs(int c);
      logic [39:0] v;
      v = normLowSpeedTxData;
      for (int k = 0; k < 10; k++) v[10*c+k] = hostIfAddressPins[k+5];
      return v;
   endfunction

   task automatic settle();
      repeat (8) @(posedge core_clk);
   endtask

   // ==========================================
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      rst = 1'b1;
      xauiStateMachineSelect = 1'b0;
      xauiLinkStateIn = 8'h00;
      rxByteClockZero = 4'h5;
      txRefClockIn = 4'h3;
      testModeInputs = 2'h0;
      fabricSpi4EnableInput = 1'b0;
      txByteClock = 4'ha;
      codeViolationFlag = 4'h6;
      byteSyncFlag = 4'hc;
      wordSyncFlag = 4'h3;
      rxByteClockOne = 4'h9;
      lowSpeedRxData = 40'h9a5c3f1e27;
      hostIfAddressPins = 11'h5a5;
      normTxByteClock = 4'h9;
      normLowSpeedTxData = 40'h123456789a;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rdChk(CLK, 32'h0);
      rdChk(STA, 32'h0);
      `CHK(hostIfDataPinsOeN, 1'b1)
      wr(CLK, 32'hffffffff);
      rdChk(CLK, 32'hf1);
      `CHK(alignmentFifoBypass, 1'b1)
      apb(1'b1, CLK, 32'h0, 4'he);
      rdChk(CLK, 32'hf1);
      wr(CLK, 32'h0);
      `CHK(alignmentFifoBypass, 1'b0)
      wr(CHR, 32'hffffffff);
      rdChk(CHR, 32'hf0);
      wr(CHR, 32'h0);
      apb(1'b0, 20'h00000, 32'h0, 4'hf);
      `CHK(rdErr, 1'b1)
      // Link status, with an unused input code
      xauiStateMachineSelect <= 1'b1;
      xauiLinkStateIn <= 8'he4;
      repeat (3) @(posedge core_clk);
      rdChk(STA, 32'h24);
      wr(STA, 32'hff);
      rdChk(STA, 32'h24);
      xauiLinkStateIn <= 8'h1b;
      repeat (3) @(posedge core_clk);
      rdChk(STA, 32'h18);
      xauiStateMachineSelect <= 1'b0;
      repeat (3) @(posedge core_clk);
      rdChk(STA, 32'h0);
      // Reference clock sources, rx and tx set independently
      for (int s = 0; s < 4; s++) begin
         wr(CLK, {24'h0, 2'(3 - s), 2'(s), 4'h0});
         for (int c = 0; c < 4; c++) begin
            rxByteClockZero <= 4'(1 << c);
            txRefClockIn <= ~4'(1 << c);
            @(posedge core_clk);
            `CHK(sharedRxRefClockOut, 1'(c == chOf[s]))
            `CHK(sharedTxRefClockOut, 1'(c != chOf[3-s]))
         end
      end
      rxByteClockZero <= 4'h5;
      // Characterization observation on every channel
      for (int f = 0; f < 4; f++) begin
         wr(CHR, {24'h0, 2'(f), 2'b01, 4'h0});
         settle();
         `CHK(hostIfDataPinsOeN, 1'b0)
         `CHK(hostIfDataPinsOut, expPins(f))
         `CHK(lowSpeedTxData, normLowSpeedTxData)
      end
      wr(CHR, 32'hb0);
      settle();
      `CHK(lowSpeedTxData, expLs(2))
      `CHK(txByteClockOut, 4'hd)
      testModeInputs <= 2'h1;
      settle();
      `CHK(hostIfDataPinsOeN, 1'b1)
      `CHK(hostIfDataPinsOut, 16'h0)
      `CHK(lowSpeedTxData, normLowSpeedTxData)
      `CHK(txByteClockOut, 4'h9)
      testModeInputs <= 2'h0;
      fabricSpi4EnableInput <= 1'b1;
      settle();
      `CHK(hostIfDataPinsOeN, 1'b1)
      fabricSpi4EnableInput <= 1'b0;
      settle();
      `CHK(txByteClockOut, 4'hd)
      // Reset in mid-run
      wr(CLK, 32'h01);
      rst <= 1'b1;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      `CHK(alignmentFifoBypass, 1'b0)
      rdChk(CLK, 32'h0);
      rdChk(CHR, 32'h0);
      give_verdict();
   end
endmodule
`default_nettype wire
